/* File: hdl/ids_regs.v */
// register bank: indirect access window, selftest control, strap decode status
// assumes a synchronous byte register port from the serial-control slave
// Operation
// - data write performs indirect block write
// - data read returns selected block register
// - output mode 00 disables, 10 enables
// - config source: one follows pin, zero register
// - selftest enable forwards clock source remotely
// - index done flag at bit seven
// - index strap value at bits six-four
// - mode done flag at bit three
// - mode strap value at bits two-zero
// - target select picks internal block
// - offset register holds indirect offset
// - auto-increment bumps offset after access
// - prefetch read strobe on offset write
`timescale 1ns/10ps
`default_nettype none
`include "ids_regs_defs.vh"
module ids_regs #(
    parameter STRAP_SETTLE = 4
) (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    output reg  [3:0] blk_sel_o,
    output reg  [7:0] blk_offset_o,
    output reg  [7:0] blk_wdata_o,
    output reg        blk_wr_o,
    output reg        blk_rd_o,
    input  wire [7:0] blk_rdata_i,
    input  wire       selftest_pin_i,
    input  wire [2:0] selftest_pin_cfg_i,
    output reg        selftest_active_o,
    output reg        selftest_out_en_o,
    output reg  [1:0] selftest_clk_src_o,
    output reg        remote_wr_o,
    output reg  [7:0] remote_offset_o,
    output reg  [1:0] remote_clk_src_o,
    input  wire [2:0] index_strap_i,
    input  wire [2:0] mode_strap_i
);
    reg        rst1_ff;
    reg        rst2_ff;
    reg        pin1_ff;
    reg        pin2_ff;
    reg  [2:0] pcfg1_ff;
    reg  [2:0] pcfg2_ff;
    reg  [7:0] ctl_ff;
    reg  [7:0] st_ctl_ff;
    reg  [7:0] rsv4_ff;
    reg  [7:0] rsv5_ff;
    reg  [7:0] rsv6_ff;
    reg  [7:0] rsv7_ff;
    reg        st_prev_ff;
    reg  [7:0] nxt_rdata;
    reg        eff_en;
    reg  [1:0] eff_src;
    wire       rst_n;
    wire [2:0] index_strap_value;
    wire       index_strap_done;
    wire [2:0] mode_strap_value;
    wire       mode_strap_done;
    wire       hit_data;
    wire       acc_done;

    assign rst_n = rst2_ff;

    // reset release through two flops
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst1_ff <= 1'b0;
            rst2_ff <= 1'b0;
        end else begin
            rst1_ff <= 1'b1;
            rst2_ff <= rst1_ff;
        end
    end

    // selftest pins come from outside, synchronise them
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin1_ff  <= 1'b0;
            pin2_ff  <= 1'b0;
            pcfg1_ff <= 3'h0;
            pcfg2_ff <= 3'h0;
        end else begin
            pin1_ff  <= selftest_pin_i;
            pin2_ff  <= pin1_ff;
            pcfg1_ff <= selftest_pin_cfg_i;
            pcfg2_ff <= pcfg1_ff;
        end
    end

    ids_strap_decoder #(.SETTLE(STRAP_SETTLE)) u_index (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .strap_i (index_strap_i),
        .value_o (index_strap_value),
        .done_o  (index_strap_done)
    );

    ids_strap_decoder #(.SETTLE(STRAP_SETTLE)) u_mode (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .strap_i (mode_strap_i),
        .value_o (mode_strap_value),
        .done_o  (mode_strap_done)
    );

    assign hit_data = (reg_addr_i == `IDS_OFS_IND_DATA);
    // a data-port read completes at its own edge; a write only after its strobe
    assign acc_done = hit_data && reg_rd_i;

    // host-visible registers and indirect strobes
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff       <= `IDS_RST_ZERO;
            blk_offset_o <= `IDS_RST_ZERO;
            blk_wdata_o  <= `IDS_RST_ZERO;
            st_ctl_ff    <= `IDS_RST_ST_CTL;
            rsv4_ff      <= `IDS_RST_RSV_B4;
            rsv5_ff      <= `IDS_RST_RSV_B5;
            rsv6_ff      <= `IDS_RST_RSV_B6;
            rsv7_ff      <= `IDS_RST_RSV_B7;
            blk_wr_o     <= 1'b0;
            blk_rd_o     <= 1'b0;
        end else begin
            blk_wr_o <= 1'b0;
            blk_rd_o <= 1'b0;
            // bump only once the block has taken the strobe at the selected offset;
            // a host offset write in the same cycle overrides it below
            if (blk_wr_o && ctl_ff[`IDS_CTL_AUTO_INC]) begin
                blk_offset_o <= blk_offset_o + `IDS_ONE;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `IDS_OFS_IND_CTL: begin
                        ctl_ff <= reg_wdata_i & `IDS_CTL_WMASK;
                    end
                    `IDS_OFS_IND_OFFSET: begin
                        blk_offset_o <= reg_wdata_i;
                        blk_rd_o     <= ctl_ff[`IDS_CTL_PREFETCH];
                    end
                    `IDS_OFS_IND_DATA: begin
                        blk_wdata_o <= reg_wdata_i;
                        blk_wr_o    <= 1'b1;
                    end
                    `IDS_OFS_ST_CTL: st_ctl_ff <= reg_wdata_i;
                    `IDS_OFS_RSV_B4: rsv4_ff <= reg_wdata_i;
                    `IDS_OFS_RSV_B5: rsv5_ff <= reg_wdata_i;
                    `IDS_OFS_RSV_B6: rsv6_ff <= reg_wdata_i;
                    `IDS_OFS_RSV_B7: rsv7_ff <= reg_wdata_i;
                    default: ;
                endcase
            end
            // read data was taken at the old offset; limitation: a data read right
            // after a data write needs one spare cycle to see the bumped offset
            if (acc_done && ctl_ff[`IDS_CTL_AUTO_INC]) begin
                blk_offset_o <= blk_offset_o + `IDS_ONE;
                blk_rd_o     <= ctl_ff[`IDS_CTL_PREFETCH];
            end
        end
    end

    // select follows the control register a cycle late; reserved codes pass as they are
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            blk_sel_o <= 4'h0;
        end else begin
            blk_sel_o <= ctl_ff[`IDS_CTL_SEL_HI:`IDS_CTL_SEL_LO];
        end
    end

    // effective selftest controls, pin or register sourced
    always @* begin
        if (st_ctl_ff[`IDS_ST_PIN_CFG]) begin
            eff_en  = pin2_ff;
            eff_src = pcfg2_ff[`IDS_ST_CLK_SRC_HI:`IDS_ST_CLK_SRC_LO];
        end else begin
            eff_en  = st_ctl_ff[`IDS_ST_EN];
            eff_src = st_ctl_ff[`IDS_ST_CLK_SRC_HI:`IDS_ST_CLK_SRC_LO];
        end
    end

    // selftest outputs and remote clock-source forwarding
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_prev_ff         <= 1'b0;
            selftest_active_o  <= 1'b0;
            selftest_out_en_o  <= 1'b0;
            selftest_clk_src_o <= 2'b00;
            remote_wr_o        <= 1'b0;
            remote_offset_o    <= `IDS_REMOTE_CLK_OFS;
            remote_clk_src_o   <= 2'b00;
        end else begin
            st_prev_ff         <= eff_en;
            selftest_active_o  <= eff_en;
            selftest_clk_src_o <= eff_src;
            // reserved codes treated as disabled, the safe choice
            selftest_out_en_o  <= eff_en &&
                (st_ctl_ff[`IDS_ST_OUT_MODE_HI:`IDS_ST_OUT_MODE_LO] == `IDS_OUT_MODE_EN);
            // no check on value three: choosing a safe source is the host's job
            remote_wr_o        <= eff_en && !st_prev_ff;
            if (eff_en && !st_prev_ff) begin
                remote_clk_src_o <= eff_src;
            end
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        case (reg_addr_i)
            `IDS_OFS_IND_CTL:    nxt_rdata = ctl_ff;
            `IDS_OFS_IND_OFFSET: nxt_rdata = blk_offset_o;
            `IDS_OFS_IND_DATA:   nxt_rdata = blk_rdata_i;
            `IDS_OFS_ST_CTL:     nxt_rdata = st_ctl_ff;
            `IDS_OFS_RSV_B4:     nxt_rdata = rsv4_ff;
            `IDS_OFS_RSV_B5:     nxt_rdata = rsv5_ff;
            `IDS_OFS_RSV_B6:     nxt_rdata = rsv6_ff;
            `IDS_OFS_RSV_B7:     nxt_rdata = rsv7_ff;
            `IDS_OFS_STRAP_STS:  nxt_rdata = {index_strap_done, index_strap_value,
                                              mode_strap_done, mode_strap_value};
            default:             nxt_rdata = `IDS_RST_ZERO;
        endcase
    end

    // read data registered, held until the next read
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= `IDS_RST_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end
    end
endmodule // ids_regs
`default_nettype wire

/* File: hdl/ids_regs_defs.vh */
// register offsets, field positions and reset values of the indirect/selftest/strap bank
// assumes an 8-bit register port with 8-bit offsets
`ifndef IDS_REGS_DEFS_VH
`define IDS_REGS_DEFS_VH
`define IDS_OFS_IND_CTL      8'hb0
`define IDS_OFS_IND_OFFSET   8'hb1
`define IDS_OFS_IND_DATA     8'hb2
`define IDS_OFS_ST_CTL       8'hb3
`define IDS_OFS_RSV_B4       8'hb4
`define IDS_OFS_RSV_B5       8'hb5
`define IDS_OFS_RSV_B6       8'hb6
`define IDS_OFS_RSV_B7       8'hb7
`define IDS_OFS_STRAP_STS    8'hb8
`define IDS_RST_RSV_B4       8'h25
`define IDS_RST_RSV_B5       8'h00
`define IDS_RST_RSV_B6       8'h18
`define IDS_RST_RSV_B7       8'h00
`define IDS_RST_ST_CTL       8'h08
`define IDS_RST_ZERO         8'h00
`define IDS_ST_OUT_MODE_HI   7
`define IDS_ST_OUT_MODE_LO   6
`define IDS_ST_RSV_HI        5
`define IDS_ST_RSV_LO        4
`define IDS_ST_PIN_CFG       3
`define IDS_ST_CLK_SRC_HI    2
`define IDS_ST_CLK_SRC_LO    1
`define IDS_ST_EN            0
`define IDS_OUT_MODE_DIS     2'b00
`define IDS_OUT_MODE_EN      2'b10
`define IDS_CTL_SEL_HI       5
`define IDS_CTL_SEL_LO       2
`define IDS_CTL_AUTO_INC     1
`define IDS_CTL_PREFETCH     0
`define IDS_CTL_WMASK        8'h3f
`define IDS_SEL_RSV_BIT      3
`define IDS_REMOTE_CLK_OFS   8'h14
`define IDS_ONE              8'h01
`define IDS_SYNC_FILL        8'h02
`endif

/* File: hdl/ids_strap_decoder.v */
// strap decoder: samples a 3-bit strap level after reset release and latches it
// assumes the strap code arrives already digitised and steady around reset
`timescale 1ns/10ps
`default_nettype none
`include "ids_regs_defs.vh"
module ids_strap_decoder #(
    parameter SETTLE = 4
) (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire [2:0] strap_i,
    output reg  [2:0] value_o,
    output reg        done_o
);
    reg [2:0] sync1_ff;
    reg [2:0] sync2_ff;
    reg [7:0] cnt_ff;

    // two-stage synchroniser, then a settle count before latching;
    // the count covers the sync fill, so even a zero settle never latches a blank stage
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            cnt_ff   <= 8'h00;
            value_o  <= 3'h0;
            done_o   <= 1'b0;
        end else begin
            sync1_ff <= strap_i;
            sync2_ff <= sync1_ff;
            if (!done_o) begin
                if (cnt_ff == SETTLE[7:0] + `IDS_SYNC_FILL) begin
                    value_o <= sync2_ff;
                    done_o  <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
        end
    end
endmodule // ids_strap_decoder
`default_nettype wire

/* File: sim/ids_regs_props.sv */
// assertions on the ports of the indirect/selftest/strap bank
// assumes a single clock and the reset pin as disable
`timescale 1ns/10ps
`default_nettype none
`include "ids_regs_defs.vh"
module ids_regs_props (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] blk_offset_o,
    input wire logic [7:0] blk_wdata_o,
    input wire logic       blk_wr_o,
    input wire logic       blk_rd_o,
    input wire logic [7:0] blk_rdata_i,
    input wire logic       remote_wr_o,
    input wire logic [7:0] remote_offset_o
);
    // one domain, so clock and disable are stated once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // host steps that start an indirect transfer
    sequence s_dwr;
        reg_wr_i && reg_addr_i == `IDS_OFS_IND_DATA;
    endsequence
    sequence s_owr;
        reg_wr_i && reg_addr_i == `IDS_OFS_IND_OFFSET;
    endsequence
    chk_data_write: assert property (
        s_dwr |=> blk_wr_o && blk_wdata_o == $past(reg_wdata_i)) else $error("no block write");
    chk_write_target: assert property (
        s_dwr ##0 !blk_wr_o |=> blk_wr_o && $stable(blk_offset_o))
        else $error("write offset moved");
    chk_write_cause: assert property (
        blk_wr_o |-> $past(reg_wr_i && reg_addr_i == `IDS_OFS_IND_DATA)) else $error("stray write");
    chk_data_read: assert property (
        reg_rd_i && reg_addr_i == `IDS_OFS_IND_DATA |=> reg_rdata_o == $past(blk_rdata_i))
        else $error("indirect read data wrong");
    chk_offset_load: assert property (
        s_owr |=> blk_offset_o == $past(reg_wdata_i)) else $error("offset not loaded");
    chk_offset_hold: assert property (
        $changed(blk_offset_o) |-> $past(reg_wr_i || reg_rd_i || blk_wr_o))
        else $error("offset moved idle");
    chk_read_strobe: assert property (
        blk_rd_o |-> $past(reg_wr_i && reg_addr_i == `IDS_OFS_IND_OFFSET || reg_rd_i
        && reg_addr_i == `IDS_OFS_IND_DATA)) else $error("stray read strobe");
    chk_remote_fixed: assert property (
        remote_offset_o == `IDS_REMOTE_CLK_OFS) else $error("remote offset wrong");
    chk_remote_single: assert property (
        remote_wr_o |=> !remote_wr_o) else $error("remote write not single");
endmodule // ids_regs_props
bind ids_regs ids_regs_props ids_regs_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .blk_offset_o(blk_offset_o),
    .blk_wdata_o(blk_wdata_o), .blk_wr_o(blk_wr_o), .blk_rd_o(blk_rd_o),
    .blk_rdata_i(blk_rdata_i), .remote_wr_o(remote_wr_o), .remote_offset_o(remote_offset_o));
`default_nettype wire

/* File: sim/ids_blk_model.sv */
// model of the indirect target block behind the data window
// assumes one-cycle write strobes; only target 0 is populated
`timescale 1ns/10ps
`default_nettype none
module ids_blk_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] blk_sel_i,
    input  wire logic [7:0] blk_offset_i,
    input  wire logic [7:0] blk_wdata_i,
    input  wire logic       blk_wr_i,
    output logic      [7:0] blk_rdata_o
);
    logic [7:0] mem_ff [256];
    // inverse-of-offset fill, so a wrong offset reads back visibly
    initial for (int i = 0; i < 256; i++) mem_ff[i] = ~i[7:0];
    always @(posedge clk_i) if (blk_wr_i && blk_sel_i == 4'h0) mem_ff[blk_offset_i] <= blk_wdata_i;
    // other targets are empty here and read zero
    assign blk_rdata_o = (blk_sel_i == 4'h0) ? mem_ff[blk_offset_i] : 8'h00;
endmodule // ids_blk_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the indirect/selftest/strap bank
// assumes ids_regs, its checker and the block model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rv;
    logic       st_pin = 1'b0;
    logic [2:0] st_cfg = 3'h0, idx_strap = 3'h5, mode_strap = 3'h3;
    wire  [7:0] reg_rdata_o, blk_offset_o, blk_wdata_o, blk_rdata_i, remote_offset_o;
    wire  [3:0] blk_sel_o;
    wire  [1:0] st_src, remote_clk_src_o;
    wire        blk_wr_o, blk_rd_o, st_act, st_oen, remote_wr_o;
    int         mismatches = 0, comparisons = 0;
    ids_regs #(.STRAP_SETTLE(1)) ids_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .blk_sel_o(blk_sel_o),
        .blk_offset_o(blk_offset_o), .blk_wdata_o(blk_wdata_o), .blk_wr_o(blk_wr_o),
        .blk_rd_o(blk_rd_o), .blk_rdata_i(blk_rdata_i), .selftest_pin_i(st_pin),
        .selftest_pin_cfg_i(st_cfg), .selftest_active_o(st_act), .selftest_out_en_o(st_oen),
        .selftest_clk_src_o(st_src), .remote_wr_o(remote_wr_o),
        .remote_offset_o(remote_offset_o), .remote_clk_src_o(remote_clk_src_o),
        .index_strap_i(idx_strap), .mode_strap_i(mode_strap));
    ids_blk_model ids_blk_model_inst (.clk_i(clk_i), .blk_sel_i(blk_sel_o),
        .blk_offset_i(blk_offset_o), .blk_wdata_i(blk_wdata_o), .blk_wr_i(blk_wr_o),
        .blk_rdata_o(blk_rdata_i));
    always #2 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one register access; results settle 1 ns after the taking edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset_vals;
        logic [7:0] exp [4];
        exp = '{8'h25, 8'h00, 8'h18, 8'h00};
        for (int i = 0; i < 4; i++) begin
            acc(0, 8'hb4 + i[7:0], 8'h00);
            chk("rsvd", rv, exp[i]);
        end
        acc(0, 8'hb3, 8'h00);
        chk("st_ctl", rv, 8'h08);
        acc(0, 8'h55, 8'h00);
        chk("unmapped", rv, 8'h00);
    endtask
    task automatic t_strap;
        acc(0, 8'hb8, 8'h00);
        chk("strap", rv, 8'hdb);
        acc(1, 8'hb8, 8'h00);
        acc(0, 8'hb8, 8'h00);
        chk("strap_ro", rv, 8'hdb);
    endtask
    task automatic t_indirect;
        acc(1, 8'hb0, 8'hdc);
        acc(0, 8'hb0, 8'h00);
        chk("ctl", rv, 8'h1c);
        chk("sel", blk_sel_o, 8'h07);
        acc(1, 8'hb0, 8'h03);
        acc(1, 8'hb1, 8'h10);
        chk("prefetch", blk_rd_o, 8'h01);
        acc(0, 8'hb2, 8'h00);
        chk("rdata", rv, 8'hef);
        chk("inc_rd", blk_offset_o, 8'h11);
        chk("refetch", blk_rd_o, 8'h01);
        acc(1, 8'hb1, 8'hfe);
        chk("offset", blk_offset_o, 8'hfe);
        acc(1, 8'hb2, 8'h3c);
        chk("bwr", blk_wr_o, 8'h01);
        chk("bwdata", blk_wdata_o, 8'h3c);
        acc(1, 8'hb2, 8'hc3);
        step;
        chk("wrap", blk_offset_o, 8'h00);
        acc(1, 8'hb0, 8'h00);
        acc(1, 8'hb1, 8'h20);
        chk("no_pref", blk_rd_o, 8'h00);
        acc(0, 8'hb2, 8'h00);
        chk("rdata2", rv, 8'hdf);
        chk("no_inc", blk_offset_o, 8'h20);
        acc(1, 8'hb1, 8'hfe);
        acc(0, 8'hb2, 8'h00);
        chk("wr_land", rv, 8'h3c);
        acc(1, 8'hb1, 8'hff);
        acc(0, 8'hb2, 8'h00);
        chk("wr_land2", rv, 8'hc3);
    endtask
    task automatic wait_remote(input logic [1:0] src);
        for (int n = 0; n < 8 && remote_wr_o !== 1'b1; n++) step;
        chk("remote_wr", remote_wr_o, 8'h01);
        chk("remote_src", remote_clk_src_o, src);
        chk("st_src", st_src, src);
    endtask
    task automatic t_selftest;
        acc(1, 8'hb3, 8'h85); // source 2, never 3
        wait_remote(2'h2);
        chk("active", st_act, 8'h01);
        chk("out_en", st_oen, 8'h01);
        acc(1, 8'hb3, 8'h05);
        step;
        chk("out_dis", st_oen, 8'h00);
        acc(1, 8'hb3, 8'h04);
        step;
        chk("stopped", st_act, 8'h00);
        @(posedge clk_i);
        st_cfg <= 3'h2;
        acc(1, 8'hb3, 8'h08);
        @(posedge clk_i);
        st_pin <= 1'b1;
        wait_remote(2'h1);
        @(posedge clk_i);
        st_pin <= 1'b0;
    endtask
    // second reset in mid-run with other strap codes; the bank must come back clean
    task automatic t_reset_mid;
        @(posedge clk_i);
        rst_n_i    <= 1'b0;
        idx_strap  <= 3'h2;
        mode_strap <= 3'h6;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        #1;
        chk("rst_ofs", blk_offset_o, 8'h00);
        acc(0, 8'hb8, 8'h00);
        chk("strap2", rv, 8'hae);
        acc(0, 8'hb3, 8'h00);
        chk("st_ctl2", rv, 8'h08);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        t_reset_vals;
        t_strap;
        t_indirect;
        t_selftest;
        t_reset_mid;
        conclude;
    end
    // watchdog well beyond the hundred-odd cycles the run needs
    initial begin
        repeat (4000) @(posedge clk_i);
        mismatches++;
        conclude;
    end
endmodule // tb_top
`default_nettype wire
